/* hw/cbi_core.sv */
// Bus-off recovery, interrupt flags, receive timeout and trigger timers.
`timescale 1ns/1ps
`default_nettype none
module cbi_core
    import cbi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cbi_line_type line,
    input wire logic rx_frame_done,
    input wire logic tx_request,
    output logic tx_start,
    output logic rx_accept,
    output logic irq_request,
    output var logic [CBI_TIMERS-1:0] trig_tx_fire
);
    cbi_state_type state_q;
    cbi_req_type req_q;
    logic init_hold_bit_q;
    logic busoff_flag_q;
    logic [2:0] last_error_code_q;
    logic [1:0] activity_state_q;
    logic [7:0] rx_error_count_q;
    logic [8:0] tx_error_count_q;
    logic [3:0] recessive_run_q;
    logic idle_min_q;
    logic [CBI_IRQ_W-1:0] irq_flag_q;
    logic [CBI_IRQ_W-1:0] irq_flag_prev_q;
    logic [CBI_IRQ_W-1:0] irq_enable_q;
    logic [15:0] rx_timeout_reload_q;
    logic rx_timeout_irq_enable_q;
    logic [15:0] rx_timeout_count_q;
    logic [CBI_PRESC_W-1:0] presc_q [CBI_CHANNELS];
    logic [CBI_PRESC_W-1:0] presc_cnt_q [CBI_CHANNELS];
    logic [CBI_TRIG_RELOAD_W-1:0] reload_q [CBI_TIMERS];
    logic [CBI_TRIG_RELOAD_W-1:0] tcount [CBI_TIMERS];
    logic [CBI_TIMERS-1:0] trunning;
    logic [CBI_TIMERS-1:0] tload;
    logic [CBI_CHANNELS-1:0] chan_tick;
    logic wr_en;
    logic idle_seen;
    logic busoff_entry;
    logic rx_timeout_event;
    logic [CBI_IRQ_W-1:0] hw_set;
    logic [CBI_IRQ_W-1:0] sw_clr;
    logic [CBI_IRQ_W-1:0] irq_gate;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = req_q.sel && req_q.write;

    // Address phase is captured; the data phase completes without waits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.sel <= hsel && htrans[1];
            req_q.write <= hwrite;
            req_q.addr <= haddr[7:0];
        end
    end

    // An eleventh consecutive recessive bit marks one bus-idle occurrence.
    assign idle_seen = line.bit_tick && !line.rx_dominant &&
        (recessive_run_q == 4'(CBI_IDLE_BITS - 1));
    assign busoff_entry = (state_q == CBI_ST_RUN) &&
        (tx_error_count_q > {1'b0, CBI_BUSOFF_LIMIT});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            recessive_run_q <= '0;
        end else if (state_q == CBI_ST_HOLD) begin
            // A stale run must not shorten the first idle of recovery.
            recessive_run_q <= '0;
        end else if (line.bit_tick) begin
            if (line.rx_dominant || idle_seen) begin
                recessive_run_q <= '0;
            end else begin
                recessive_run_q <= recessive_run_q + 4'h1;
            end
        end
    end

    // Recovery sequencer; the hold bit also reflects software writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= CBI_ST_RUN;
            init_hold_bit_q <= CBI_CTRL_RESET[0];
            busoff_flag_q <= 1'b0;
            activity_state_q <= CBI_ACT_SYNC;
            idle_min_q <= 1'b0;
        end else begin
            unique case (state_q)
                CBI_ST_RUN: begin
                    if (busoff_entry) begin
                        busoff_flag_q <= 1'b1;
                        init_hold_bit_q <= 1'b1;
                        activity_state_q <= CBI_ACT_SYNC;
                        state_q <= CBI_ST_HOLD;
                    end else if (wr_en && hit(req_q.addr, CBI_CTRL_OFF)) begin
                        init_hold_bit_q <= hwdata[0];
                    end else if (init_hold_bit_q) begin
                        activity_state_q <= CBI_ACT_SYNC;
                    end else if (line.bit_tick) begin
                        idle_min_q <= activity_state_q == CBI_ACT_IDLE;
                        if (activity_state_q == CBI_ACT_SYNC) begin
                            activity_state_q <= CBI_ACT_IDLE;
                            idle_min_q <= 1'b0;
                        end else if (activity_state_q == CBI_ACT_IDLE &&
                                     idle_min_q) begin
                            if (line.rx_dominant) begin
                                activity_state_q <= CBI_ACT_RX;
                            end else if (tx_request) begin
                                activity_state_q <= CBI_ACT_TX;
                            end
                        end else if (activity_state_q != CBI_ACT_IDLE &&
                                     (rx_frame_done || line.tx_success)) begin
                            activity_state_q <= CBI_ACT_IDLE;
                            idle_min_q <= 1'b0;
                        end
                    end
                end
                CBI_ST_HOLD: begin
                    if (wr_en && hit(req_q.addr, CBI_CTRL_OFF) && !hwdata[0]) begin
                        init_hold_bit_q <= 1'b0;
                        state_q <= CBI_ST_RECOV;
                    end
                end
                CBI_ST_RECOV: begin
                    // Sync activity and a set bus-off flag hold here.
                    activity_state_q <= CBI_ACT_SYNC;
                    if (idle_seen &&
                        rx_error_count_q == 8'(CBI_IDLE_NEEDED - 1)) begin
                        busoff_flag_q <= 1'b0;
                        state_q <= CBI_ST_SETTLE;
                    end
                end
                CBI_ST_SETTLE: begin
                    if (line.bit_tick) begin
                        activity_state_q <= CBI_ACT_IDLE;
                        idle_min_q <= 1'b0;
                        state_q <= CBI_ST_RUN;
                    end
                end
            endcase
        end
    end

    // The receive error counter doubles as the idle-occurrence counter in recovery.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_error_count_q <= '0;
            tx_error_count_q <= '0;
            last_error_code_q <= '0;
        end else if (state_q == CBI_ST_RECOV) begin
            if (idle_seen) begin
                rx_error_count_q <= rx_error_count_q + 8'h01;
                last_error_code_q <= CBI_LEC_DOM;
                if (rx_error_count_q == 8'(CBI_IDLE_NEEDED - 1)) begin
                    rx_error_count_q <= '0;
                    tx_error_count_q <= '0;
                end
            end
        end else if (state_q == CBI_ST_RUN && !init_hold_bit_q) begin
            if (line.tx_error) begin
                tx_error_count_q <= tx_error_count_q + 9'h008;
            end else if (line.tx_success && tx_error_count_q != '0) begin
                tx_error_count_q <= tx_error_count_q - 9'h001;
            end
            if (line.rx_error && rx_error_count_q != 8'hFF) begin
                rx_error_count_q <= rx_error_count_q + 8'h01;
            end
        end
    end

    assign rx_accept = rx_frame_done && state_q == CBI_ST_RUN &&
        !init_hold_bit_q;
    assign tx_start = tx_request && state_q == CBI_ST_RUN &&
        activity_state_q == CBI_ACT_IDLE && idle_min_q &&
        line.bit_tick && !line.rx_dominant;

    // Receive timeout counts bit times since the last accepted frame.
    assign rx_timeout_event = rx_timeout_reload_q != '0 && line.bit_tick &&
        rx_timeout_count_q == 16'h0001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_timeout_count_q <= '0;
        end else if (rx_timeout_reload_q == '0 || rx_accept) begin
            rx_timeout_count_q <= rx_timeout_reload_q;
        end else if (line.bit_tick && rx_timeout_count_q != '0) begin
            rx_timeout_count_q <= rx_timeout_count_q - 16'h0001;
        end
    end

    assign hw_set[CBI_IRQ_PEA] = state_q == CBI_ST_RECOV && idle_seen;
    assign hw_set[CBI_IRQ_BO] = busoff_entry;
    assign hw_set[CBI_IRQ_RXTO] = rx_timeout_event;
    assign hw_set[CBI_IRQ_TRIG] = |trig_tx_fire;
    assign sw_clr = (wr_en && hit(req_q.addr, CBI_IRQ_OFF)) ?
        hwdata[CBI_IRQ_W-1:0] : '0;

    // The timeout flag lets the clear win; every other flag favours the set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flag_q <= '0;
            irq_flag_prev_q <= '0;
        end else begin
            irq_flag_prev_q <= irq_flag_q;
            for (int i = 0; i < CBI_IRQ_W; i++) begin
                if (i == CBI_IRQ_RXTO) begin
                    irq_flag_q[i] <= !sw_clr[i] &&
                        (irq_flag_q[i] || hw_set[i]);
                end else begin
                    irq_flag_q[i] <= hw_set[i] ||
                        (irq_flag_q[i] && !sw_clr[i]);
                end
            end
        end
    end

    // The timeout flag needs its own enable as well before it may ask.
    always_comb begin
        irq_gate = '1;
        irq_gate[CBI_IRQ_RXTO] = rx_timeout_irq_enable_q;
    end

    // Only a rising flag asks for service, so a stuck flag stays quiet.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= |(irq_flag_q & ~irq_flag_prev_q & irq_enable_q &
                irq_gate);
        end
    end

    // Configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable_q <= '0;
            rx_timeout_reload_q <= '0;
            rx_timeout_irq_enable_q <= 1'b0;
        end else if (wr_en) begin
            if (hit(req_q.addr, CBI_IEN_OFF)) begin
                irq_enable_q <= hwdata[CBI_IRQ_W-1:0];
            end
            if (hit(req_q.addr, CBI_RXTO_OFF)) begin
                rx_timeout_reload_q <= hwdata[15:0];
                rx_timeout_irq_enable_q <= hwdata[31];
            end
        end
    end

    // Per-channel prescalers, each shared by that channel's three timers.
    genvar c, t;
    generate
        for (c = 0; c < CBI_CHANNELS; c++) begin : g_chan
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    presc_q[c] <= '0;
                    presc_cnt_q[c] <= '0;
                end else begin
                    if (wr_en && hit(req_q.addr,
                        CBI_TCFG_OFF + 8'(c * 4))) begin
                        presc_q[c] <= hwdata[CBI_PRESC_W-1:0];
                    end
                    presc_cnt_q[c] <= chan_tick[c] ? '0 :
                        presc_cnt_q[c] + 1'b1;
                end
            end
            assign chan_tick[c] = presc_cnt_q[c] >= presc_q[c];
        end
        for (t = 0; t < CBI_TIMERS; t++) begin : g_timer
            assign tload[t] = wr_en &&
                hit(req_q.addr, CBI_TRIG_OFF + 8'(t * 4));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    reload_q[t] <= '0;
                end else if (tload[t]) begin
                    reload_q[t] <= hwdata[CBI_TRIG_RELOAD_W-1:0];
                end
            end
            cbi_trig_timer u_timer (
                .hclk(hclk),
                .hresetn(hresetn),
                .load(tload[t]),
                .reload(reload_q[t]),
                .start(hwdata[CBI_TRIG_TIMER_START_BIT_BIT]),
                .tick(chan_tick[t / 3]),
                .count_q(tcount[t]),
                .running_q(trunning[t]),
                .fire_q(trig_tx_fire[t])
            );
        end
    endgenerate

    // Read data is combinational from state; unmapped words read zero.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (req_q.sel && !req_q.write) begin
            if (hit(req_q.addr, CBI_CTRL_OFF)) begin
                hrdata = {31'h0, init_hold_bit_q};
            end else if (hit(req_q.addr, CBI_STAT_OFF)) begin
                hrdata = {26'h0, busoff_flag_q, activity_state_q,
                    last_error_code_q};
            end else if (hit(req_q.addr, CBI_ERR_OFF)) begin
                hrdata = {15'h0, tx_error_count_q, rx_error_count_q};
            end else if (hit(req_q.addr, CBI_IRQ_OFF)) begin
                hrdata = {28'h0, irq_flag_q};
            end else if (hit(req_q.addr, CBI_IEN_OFF)) begin
                hrdata = {28'h0, irq_enable_q};
            end else if (hit(req_q.addr, CBI_RXTO_OFF)) begin
                hrdata = {rx_timeout_irq_enable_q, 15'h0,
                    rx_timeout_reload_q};
            end else begin
                for (int i = 0; i < CBI_TIMERS; i++) begin
                    if (hit(req_q.addr, CBI_TRIG_OFF + 8'(i * 4))) begin
                        hrdata = {trunning[i], 15'h0, tcount[i]};
                    end
                end
            end
        end
    end
endmodule : cbi_core
`default_nettype wire

/* hw/cbi_pkg.sv */
// Package of constants and types for the CAN bus-off and interrupt logic.
package cbi_pkg;
    localparam logic [7:0] CBI_CTRL_OFF = 8'h00;
    localparam logic [7:0] CBI_STAT_OFF = 8'h04;
    localparam logic [7:0] CBI_ERR_OFF = 8'h08;
    localparam logic [7:0] CBI_IRQ_OFF = 8'h0C;
    localparam logic [7:0] CBI_IEN_OFF = 8'h10;
    localparam logic [7:0] CBI_RXTO_OFF = 8'h14;
    localparam logic [7:0] CBI_TCFG_OFF = 8'h18;
    localparam logic [7:0] CBI_TRIG_OFF = 8'h40;
    localparam int CBI_CHANNELS = 4;
    localparam int CBI_TIMERS = 12;
    localparam int CBI_IDLE_BITS = 11;
    localparam int CBI_IDLE_NEEDED = 129;
    localparam logic [2:0] CBI_LEC_DOM = 3'h5;
    localparam logic [1:0] CBI_ACT_SYNC = 2'h0;
    localparam logic [1:0] CBI_ACT_IDLE = 2'h1;
    localparam logic [1:0] CBI_ACT_RX = 2'h2;
    localparam logic [1:0] CBI_ACT_TX = 2'h3;
    localparam int CBI_IRQ_PEA = 0;
    localparam int CBI_IRQ_BO = 1;
    localparam int CBI_IRQ_RXTO = 2;
    localparam int CBI_IRQ_TRIG = 3;
    localparam int CBI_IRQ_W = 4;
    localparam logic [7:0] CBI_BUSOFF_LIMIT = 8'hFF;
    localparam logic [31:0] CBI_CTRL_RESET = 32'h0000_0001;
    localparam int CBI_TRIG_RELOAD_W = 16;
    localparam int CBI_TRIG_TIMER_START_BIT_BIT = 31;
    localparam int CBI_PRESC_W = 8;

    typedef enum logic [1:0] {
        CBI_ST_RUN = 2'b00,
        CBI_ST_HOLD = 2'b01,
        CBI_ST_RECOV = 2'b11,
        CBI_ST_SETTLE = 2'b10
    } cbi_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic sel;
    } cbi_req_type;

    typedef struct packed {
        logic rx_dominant;
        logic bit_tick;
        logic tx_error;
        logic tx_success;
        logic rx_error;
    } cbi_line_type;
endpackage : cbi_pkg

/* hw/cbi_trig_timer.sv */
// One transmit-trigger timer with reload, start bit and prescaled tick.
`timescale 1ns/1ps
`default_nettype none
module cbi_trig_timer
    import cbi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [CBI_TRIG_RELOAD_W-1:0] reload,
    input wire logic start,
    input wire logic tick,
    output var logic [CBI_TRIG_RELOAD_W-1:0] count_q,
    output var logic running_q,
    output var logic fire_q
);
    // The count runs from zero to reload inclusive and fires on the next tick, holding at reload.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= '0;
            running_q <= 1'b0;
            fire_q <= 1'b0;
        end else begin
            fire_q <= 1'b0;
            if (load) begin
                count_q <= '0;
                running_q <= start;
            end else if (running_q && tick) begin
                if (count_q == reload) begin
                    fire_q <= 1'b1;
                    running_q <= 1'b0;
                end else begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end
endmodule : cbi_trig_timer
`default_nettype wire

/* verification/cbi_can_node.sv */
// Model of the other nodes: bit pacing, bus level and error events.
`timescale 1ns/1ps
`default_nettype none
module cbi_can_node
    import cbi_pkg::*;
#(
    parameter int BIT_CYCLES = 4
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic dominant,
    input wire logic err,
    output var cbi_line_type line
);
    int div_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 0;
        end else begin
            div_q <= (run && div_q < BIT_CYCLES - 1) ? div_q + 1 : 0;
        end
    end
    // The bus rests recessive; a dominant level only while asked for.
    always_comb begin
        line.rx_dominant = dominant;
        line.bit_tick = run && div_q == BIT_CYCLES - 1;
        line.tx_error = err;
        line.tx_success = 1'b0;
        line.rx_error = 1'b0;
    end
endmodule : cbi_can_node
`default_nettype wire

/* verification/cbi_core_props.sv */
// Port checker for the bus-off, interrupt and trigger logic.
`timescale 1ns/1ps
`default_nettype none
module cbi_core_props
    import cbi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_frame_done,
    input wire logic tx_request,
    input wire logic tx_start,
    input wire logic rx_accept,
    input wire logic irq_request,
    input wire logic [CBI_TIMERS-1:0] trig_tx_fire
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_q, wr_q, hold_q;
    logic [7:0] ad_q;
    logic [3:0] ien_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
        end else if (hready) begin
            rd_q <= hsel && htrans[1] && !hwrite;
            wr_q <= hsel && htrans[1] && hwrite;
            ad_q <= haddr[7:0];
        end
    end
    // Only software writes are mirrored; a hold set by bus-off is not seen.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b1;
            ien_q <= 4'h0;
        end else if (wr_q && hready) begin
            if (ad_q == CBI_CTRL_OFF) hold_q <= hwdata[0];
            if (ad_q == CBI_IEN_OFF) ien_q <= hwdata[3:0];
        end
    end
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    AST_IRQ_PULSE: assert property (
        irq_request |=> !irq_request) else $error("request held");
    AST_IRQ_GATED: assert property (
        irq_request |-> ien_q != 4'h0) else $error("masked request");
    AST_TX_REQ: assert property (
        tx_start |-> tx_request) else $error("start unasked");
    AST_TX_HOLD: assert property (
        hold_q |-> !tx_start) else $error("start in hold");
    AST_RX_FRAME: assert property (
        rx_accept |-> rx_frame_done && !hold_q) else $error("bad accept");
    AST_UNMAPPED: assert property (rd_q && ad_q == 8'h30 |-> hrdata == 32'h0)
        else $error("unmapped data");
    AST_BO_SYNC: assert property (
        rd_q && ad_q == CBI_STAT_OFF && hrdata[5]
        |-> hrdata[4:3] == CBI_ACT_SYNC)
        else $error("activity not sync in bus-off");
    AST_FIRE_PULSE: assert property (
        |trig_tx_fire |=> (trig_tx_fire & $past(trig_tx_fire)) == '0)
        else $error("fire held");
endmodule : cbi_core_props
bind cbi_core cbi_core_props chk_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_frame_done(rx_frame_done),
    .tx_request(tx_request), .tx_start(tx_start), .rx_accept(rx_accept),
    .irq_request(irq_request), .trig_tx_fire(trig_tx_fire));
`default_nettype wire

/* verification/cbi_core_test.sv */
// Self-checking bench for the bus-off, interrupt and trigger logic.
`timescale 1ns/1ps
`default_nettype none
module cbi_core_test
    import cbi_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, dom, err;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    cbi_line_type line;
    logic rx_frame_done, tx_request, tx_start, rx_accept, irq_request;
    logic [CBI_TIMERS-1:0] trig_tx_fire;
    int seed, miscompares, checks, ticks, irqs, txs, rxs, i0, n, t, r, c, tec;
    cbi_can_node #(.BIT_CYCLES(4)) node_u (.hclk(hclk), .hresetn(hresetn),
        .run(run), .dominant(dom), .err(err), .line(line));
    cbi_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line(line),
        .rx_frame_done(rx_frame_done), .tx_request(tx_request),
        .tx_start(tx_start), .rx_accept(rx_accept),
        .irq_request(irq_request), .trig_tx_fire(trig_tx_fire));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        ticks += line.bit_tick;
        irqs += irq_request;
        txs += tx_start;
        rxs += rx_accept;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Waits on the falling edge so the tick count is never read mid-update.
    task automatic upto(input int k);
        while (ticks - n < k) @(negedge hclk);
        @(posedge hclk);
    endtask : upto
    task automatic clear_flags();
        int k;
        k = 0;
        do begin
            ahb(1'b1, CBI_IRQ_OFF, 32'hF);
            ahb(1'b0, CBI_IRQ_OFF, 32'h0);
            k++;
        end while (rd[CBI_IRQ_PEA] !== 1'b0 && k < 8);
        i0 = irqs;
    endtask : clear_flags
    task automatic errs(input int k);
        repeat (k) begin
            err <= 1'b1;
            @(posedge hclk);
            err <= 1'b0;
            @(posedge hclk);
            tec += 8;
        end
    endtask : errs
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; rx_frame_done = 1'b0;
        tx_request = 1'b0; run = 1'b0; dom = 1'b0; err = 1'b0;
        seed = 32'h7cdcb0af; tec = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, CBI_CTRL_OFF, 32'h0);
        check("ctrl reset", rd, CBI_CTRL_RESET);
        ahb(1'b1, 8'h30, $random(seed));
        ahb(1'b0, 8'h30, 32'h0);
        check("unmapped", rd, 32'h0);
        ahb(1'b1, CBI_IEN_OFF, 32'h1);
        ahb(1'b1, CBI_CTRL_OFF, 32'h0);
        $display("registers test done");
        run <= 1'b1;
        errs(31);
        ahb(1'b0, CBI_ERR_OFF, 32'h0);
        check("tec", 32'(rd[16:8]), 32'(tec));
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("no bus-off", 32'(rd[5]), 32'h0);
        errs(1);
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("bus-off", 32'(rd[5]), 32'h1);
        ahb(1'b0, CBI_CTRL_OFF, 32'h0);
        check("hold set", 32'(rd[0]), 32'h1);
        tx_request <= 1'b1;
        clear_flags();
        ahb(1'b1, CBI_CTRL_OFF, 32'h0);
        n = ticks;
        $display("bus-off entry test done");
        upto(55);
        ahb(1'b0, CBI_ERR_OFF, 32'h0);
        check("idles", 32'(rd[7:0] inside {8'h4, 8'h5}), 32'h1);
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("stat", 32'(rd[5:0]),
            {26'h0, 1'b1, CBI_ACT_SYNC, CBI_LEC_DOM});
        check("pea request", 32'(irqs - i0), 32'h1);
        clear_flags();
        rx_frame_done <= 1'b1;
        @(posedge hclk);
        rx_frame_done <= 1'b0;
        upto(80);
        check("pea again", 32'(irqs - i0), 32'h1);
        check("no accept", 32'(rxs), 32'h0);
        upto(1417);
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("bo kept", 32'(rd[5]), 32'h1);
        check("tx held", 32'(txs), 32'h0);
        upto(1422);
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("bo clear", 32'(rd[5]), 32'h0);
        ahb(1'b0, CBI_ERR_OFF, 32'h0);
        check("counters", rd, 32'h0);
        upto(1428);
        check("tx started", 32'(txs != 0), 32'h1);
        ahb(1'b0, CBI_STAT_OFF, 32'h0);
        check("act tx", 32'(rd[4:3]), 32'(CBI_ACT_TX));
        tx_request <= 1'b0;
        $display("recovery test done");
        ahb(1'b1, CBI_RXTO_OFF, 32'h8000_0003);
        ahb(1'b1, CBI_IEN_OFF, 32'h5);
        clear_flags();
        repeat (2) begin
            rx_frame_done <= 1'b1;
            @(posedge hclk);
            rx_frame_done <= 1'b0;
            n = ticks;
            upto(2);
        end
        check("no timeout", 32'(irqs - i0), 32'h0);
        upto(4);
        ahb(1'b0, CBI_IRQ_OFF, 32'h0);
        check("timeout flag", 32'(rd[CBI_IRQ_RXTO]), 32'h1);
        check("timeout req", 32'(irqs - i0), 32'h1);
        $display("receive timeout test done");
        for (c = 0; c < CBI_CHANNELS; c++) begin
            ahb(1'b1, 8'(CBI_TCFG_OFF + c * 4), 32'h7);
        end
        for (t = 0; t < CBI_TIMERS; t++) begin
            r = 2 + ($unsigned($random(seed)) % 8);
            ahb(1'b1, 8'(CBI_TRIG_OFF + t * 4),
                32'h8000_0000 | (r - 1));
            c = 0;
            while (trig_tx_fire[t] !== 1'b1 && c < 100) begin
                @(negedge hclk);
                c++;
            end
            @(posedge hclk);
            check("fire delay",
                32'(c >= 8 * r - 6 && c <= 8 * r + 3), 32'h1);
        end
        $display("trigger timer test done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        miscompares++;
        give_verdict();
    end
endmodule : cbi_core_test
`default_nettype wire
